// file: rtl/cst_cfg.svh
// charger status register bank: offsets, field positions, reset values, codes
// assumes inclusion by the package and by the design modules
`ifndef CST_CFG_SVH
`define CST_CFG_SVH
`define CST_SUMMARY_OFFSET      8'h18
`define CST_INPUT_OFFSET        8'h19
`define CST_BATT_PRESENT_BIT    7
`define CST_BATT_GOOD_BIT       6
`define CST_SUPPLY_GOOD_BIT     5
`define CST_CHG_HEALTHY_BIT     4
`define CST_SUPPLY_CODE_HI      7
`define CST_SUPPLY_CODE_LO      6
`define CST_THERMAL_FOLD_BIT    4
`define CST_SUMMARY_RESET       8'h10
`define CST_INPUT_RESET         8'h00
`define CST_UNMAPPED_DATA       8'h00
`define CST_TEMP_FIRST_C        80
`define CST_TEMP_STEP_C         5
`endif

// file: rtl/cst_pkg.sv
// charger status types: detail codes and supply condition
// assumes cst_cfg.svh for numeric constants
`include "cst_cfg.svh"
package cst_pkg;
   typedef enum logic [2:0] {
      BATT_MISSING, BATT_DETECTING, BATT_DEAD, BATT_LOW,
      BATT_BELOW_RECHG, BATT_ABOVE_RECHG, BATT_RESERVED, BATT_IN_RESET
   } cst_batt_code_t;
   typedef enum logic [2:0] {
      ZONE_NOMINAL, ZONE_COLD, ZONE_COOL, ZONE_WARM, ZONE_HOT
   } cst_temp_zone_t;
   typedef enum logic [1:0] {
      SUPPLY_UNDERVOLT, SUPPLY_NO_HEADROOM, SUPPLY_OVERVOLT, SUPPLY_VALID
   } cst_supply_code_t;
   typedef enum logic [1:0] {
      TIMER_NO_EFFECT, TIMER_PREQUAL_EXP, TIMER_FAST_EXP, TIMER_SHORT_FAIL
   } cst_timer_result_t;
endpackage : cst_pkg

// file: rtl/cst_thermal_cmp.sv
// die temperature compare against the selected regulation threshold
// assumes die temperature in whole degrees c, same clock as caller
`timescale 1ns/100ps
`include "cst_cfg.svh"
module cst_thermal_cmp (
   // clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   // threshold and measurement
   input  wire logic [2:0] die_temp_limit_sel_in,
   input  wire logic [7:0] die_temp_in,
   // result
   output logic            over_limit_out
);
   logic [7:0] limit_c;
   logic       over_r;
   logic       over_nxt;
   always_comb begin
      // 80 c plus 5 c per code step, 115 c at code 111
      limit_c  = 8'(`CST_TEMP_FIRST_C) + 8'(die_temp_limit_sel_in * `CST_TEMP_STEP_C);
      over_nxt = (die_temp_in > limit_c);
   end
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         over_r <= 1'b0;
      end else begin
         over_r <= over_nxt;
      end
   end
   assign over_limit_out = over_r;
endmodule : cst_thermal_cmp

// file: rtl/cst_status_regs.sv
// Function
// - both registers read-only, valid without current limit
// - bit7 0x18 shows battery attached
// - bit6 0x18 set for codes 001..101
// - bit5 0x18 set when supply code 11
// - bit4 0x18 clear when cold/hot or timer
// - bits7:6 0x19 encode supply condition
// - supply valid needs all three conditions
// - bit4 0x19 set above thermal threshold
// - battery condition code values per state
// - temperature zone code values per zone
// - timer result 00 means no effect
// - threshold selector 80 to 115 c
//
// charger status register bank at 0x18 and 0x19
// assumes analog comparator levels and detail codes already on clock_in;
// register port is the device's internal one behind the serial target
`timescale 1ns/100ps
`include "cst_cfg.svh"
module cst_status_regs (
   // clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   // register access from the serial target
   input  wire logic [7:0] reg_addr_in,
   input  wire logic       reg_read_in,
   input  wire logic       reg_write_in,
   input  wire logic [7:0] reg_wdata_in,
   output logic [7:0]      reg_rdata_out,
   output logic            reg_rvalid_out,
   // charger detail inputs
   input  wire logic       battery_attached_in,
   input  wire logic [2:0] battery_condition_code_in,
   input  wire logic [2:0] cell_temp_zone_in,
   input  wire logic [1:0] safety_timer_result_in,
   input  wire logic [2:0] die_temp_limit_sel_in,
   input  wire logic [7:0] die_temp_in,
   input  wire logic       input_current_limit_hit_in,
   // raw supply comparators
   input  wire logic       vin_above_uvlo_in,
   input  wire logic       vin_above_ovp_in,
   input  wire logic       sys_above_bat_headroom_in,
   // decoded flags for the rest of the charger
   output logic            battery_present_flag_out,
   output logic            supply_good_flag_out,
   output logic            charger_healthy_out,
   output logic            thermal_fold_flag_out
);
   cst_pkg::cst_supply_code_t supply_condition_code;
   logic       battery_good;
   logic       charger_healthy;
   logic       thermal_fold_flag;
   logic [7:0] summary_r;
   logic [7:0] summary_nxt;
   logic [7:0] input_r;
   logic [7:0] input_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       rvalid_r;
   logic       rvalid_nxt;

   cst_thermal_cmp u_thermal (
      .clock_in              (clock_in),
      .rst_in                (rst_in),
      .die_temp_limit_sel_in (die_temp_limit_sel_in),
      .die_temp_in           (die_temp_in),
      .over_limit_out        (thermal_fold_flag)
   );

   always_comb begin
      // undervoltage outranks overvoltage, headroom checked last
      if (!vin_above_uvlo_in) begin
         supply_condition_code = cst_pkg::SUPPLY_UNDERVOLT;
      end else if (vin_above_ovp_in) begin
         supply_condition_code = cst_pkg::SUPPLY_OVERVOLT;
      end else if (!sys_above_bat_headroom_in) begin
         supply_condition_code = cst_pkg::SUPPLY_NO_HEADROOM;
      end else begin
         supply_condition_code = cst_pkg::SUPPLY_VALID;
      end
      case (cst_pkg::cst_batt_code_t'(battery_condition_code_in))
         cst_pkg::BATT_DETECTING, cst_pkg::BATT_DEAD, cst_pkg::BATT_LOW,
         cst_pkg::BATT_BELOW_RECHG, cst_pkg::BATT_ABOVE_RECHG: battery_good = 1'b1;
         default: battery_good = 1'b0;
      endcase
      charger_healthy = 1'b1;
      if (cell_temp_zone_in == cst_pkg::ZONE_COLD || cell_temp_zone_in == cst_pkg::ZONE_HOT) begin
         charger_healthy = 1'b0;
      end else if (safety_timer_result_in != cst_pkg::TIMER_NO_EFFECT) begin
         charger_healthy = 1'b0;
      end
      // reserved bits stay zero
      summary_nxt = 8'h00;
      summary_nxt[`CST_BATT_PRESENT_BIT] = battery_attached_in;
      summary_nxt[`CST_BATT_GOOD_BIT]    = battery_good;
      summary_nxt[`CST_SUPPLY_GOOD_BIT]  =
         (supply_condition_code == cst_pkg::SUPPLY_VALID);
      summary_nxt[`CST_CHG_HEALTHY_BIT]  = charger_healthy;
      input_nxt = 8'h00;
      input_nxt[`CST_SUPPLY_CODE_HI:`CST_SUPPLY_CODE_LO] = supply_condition_code;
      input_nxt[`CST_THERMAL_FOLD_BIT] = thermal_fold_flag;
      // contents go stale while the input current limit is active: hold them
      if (input_current_limit_hit_in) begin
         summary_nxt = summary_r;
         input_nxt   = input_r;
      end
   end

   always_comb begin
      // writes never reach the status registers
      rvalid_nxt = reg_read_in;
      rdata_nxt  = `CST_UNMAPPED_DATA;
      if (reg_read_in && reg_addr_in == `CST_SUMMARY_OFFSET) begin
         rdata_nxt = summary_r;
      end else if (reg_read_in && reg_addr_in == `CST_INPUT_OFFSET) begin
         rdata_nxt = input_r;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         summary_r <= `CST_SUMMARY_RESET;
         input_r   <= `CST_INPUT_RESET;
         rdata_r   <= 8'h00;
         rvalid_r  <= 1'b0;
      end else begin
         summary_r <= summary_nxt;
         input_r   <= input_nxt;
         rdata_r   <= rdata_nxt;
         rvalid_r  <= rvalid_nxt;
      end
   end

   assign reg_rdata_out            = rdata_r;
   assign reg_rvalid_out           = rvalid_r;
   assign battery_present_flag_out = summary_r[`CST_BATT_PRESENT_BIT];
   assign supply_good_flag_out     = summary_r[`CST_SUPPLY_GOOD_BIT];
   assign charger_healthy_out      = summary_r[`CST_CHG_HEALTHY_BIT];
   assign thermal_fold_flag_out    = input_r[`CST_THERMAL_FOLD_BIT];
endmodule : cst_status_regs

// file: dv/cst_status_assertions.sv
// checker: read timing, reserved bits, flag decode and freeze of the status bank
// assumes binding into cst_status_regs, every signal on clock_in
`timescale 1ns/100ps
module cst_status_assertions (
   // clock, reset and register port
   input wire logic       clock_in, rst_in, reg_read_in, reg_rvalid_out,
   input wire logic [7:0] reg_addr_in, reg_rdata_out, die_temp_in,
   // detail inputs and decoded flags
   input wire logic [2:0] cell_temp_zone_in, die_temp_limit_sel_in,
   input wire logic [1:0] safety_timer_result_in,
   input wire logic       battery_attached_in, input_current_limit_hit_in, vin_above_uvlo_in,
   input wire logic       vin_above_ovp_in, sys_above_bat_headroom_in, battery_present_flag_out,
   input wire logic       supply_good_flag_out, charger_healthy_out, thermal_fold_flag_out
);
   default clocking @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   logic       ilim;
   logic [7:0] lim;
   assign ilim = input_current_limit_hit_in;
   assign lim = 8'h50 + 8'h05 * {5'h00, die_temp_limit_sel_in};
   chk_read_answer: assert property (reg_read_in |=> reg_rvalid_out)
      else $error("read without answer");
   chk_answer_cause: assert property (reg_rvalid_out |-> $past(reg_read_in))
      else $error("answer without read");
   chk_reserved_zero: assert property (reg_read_in && reg_addr_in[7:1] == 7'h0C
      |=> reg_rdata_out[3:0] == 4'h0) else $error("reserved bits set");
   chk_unmapped_zero: assert property (reg_read_in && reg_addr_in[7:1] != 7'h0C
      |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
   chk_present_flag: assert property (!ilim |=> battery_present_flag_out ==
      $past(battery_attached_in)) else $error("present flag wrong");
   chk_supply_flag: assert property (!ilim |=> supply_good_flag_out == $past(
      vin_above_uvlo_in && !vin_above_ovp_in && sys_above_bat_headroom_in)) else $error("supply");
   chk_healthy_flag: assert property (!ilim |=> charger_healthy_out == $past(!(cell_temp_zone_in
      inside {3'h1, 3'h4}) && safety_timer_result_in == 2'h0)) else $error("healthy flag wrong");
   chk_fold_flag: assert property (!ilim ##1 !ilim |=> thermal_fold_flag_out ==
      $past(die_temp_in > lim, 2)) else $error("fold flag wrong");
   chk_limit_hold: assert property (ilim |=> $stable(supply_good_flag_out)
      && $stable(charger_healthy_out) && $stable(battery_present_flag_out)
      && $stable(thermal_fold_flag_out)) else $error("no hold");
endmodule : cst_status_assertions
bind cst_status_regs cst_status_assertions chk (.*);

// file: dv/cst_host_model.sv
// host model: single-byte reads and writes on the register port
// assumes the bank answers a read within four cycles
`timescale 1ns/100ps
module cst_host_model (
   input  wire logic       clock_in,
   input  wire logic       rvalid_in,
   input  wire logic [7:0] rdata_in,
   output logic            read_out = 1'b0,
   output logic            write_out = 1'b0,
   output logic [7:0]      addr_out = 8'h00,
   output logic [7:0]      wdata_out = 8'h00
);
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
      ok = 0;
      @(negedge clock_in);
      read_out = 1'b1;
      addr_out = a;
      @(negedge clock_in);
      read_out = 1'b0;
      // released address is inverted so a stale value cannot pass
      addr_out = ~a;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (rvalid_in === 1'b1) begin
            d = rdata_in;
            ok = 1;
         end else @(negedge clock_in);
      end
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_in);
      write_out = 1'b1;
      addr_out = a;
      wdata_out = d;
      @(negedge clock_in);
      write_out = 1'b0;
      wdata_out = ~d;
   endtask : wr
endmodule : cst_host_model

// file: dv/testbench.sv
// testbench: random and corner detail inputs, both status registers read back
// assumes cst_host_model on the register port, inputs driven at falling edge
`timescale 1ns/100ps
module testbench;
   logic        clock_in = 0, rst_in = 1, batt = 0, ilim = 0, uv = 0, ov = 0, hd = 0;
   logic [2:0]  bc = 0, zn = 0, sel = 0;
   logic [1:0]  tm = 0, c;
   logic [7:0]  temp = 0, d, e18, e19, ad, wd, rdat;
   logic        rd, wr, rv, pf, sg, hl, tf;
   logic [31:0] s = 32'hD2E6;
   int          n_fail = 0, cmp_count = 0;
   bit          ok;
   always #25 clock_in = ~clock_in;
   cst_host_model h (.clock_in(clock_in), .rvalid_in(rv), .rdata_in(rdat), .read_out(rd),
      .write_out(wr), .addr_out(ad), .wdata_out(wd));
   cst_status_regs dut (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(ad),
      .reg_read_in(rd), .reg_write_in(wr), .reg_wdata_in(wd), .reg_rdata_out(rdat),
      .reg_rvalid_out(rv), .battery_attached_in(batt), .battery_condition_code_in(bc),
      .cell_temp_zone_in(zn), .safety_timer_result_in(tm), .die_temp_limit_sel_in(sel),
      .die_temp_in(temp), .input_current_limit_hit_in(ilim), .vin_above_uvlo_in(uv),
      .vin_above_ovp_in(ov), .sys_above_bat_headroom_in(hd), .battery_present_flag_out(pf),
      .supply_good_flag_out(sg), .charger_healthy_out(hl), .thermal_fold_flag_out(tf));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction : xs
   task summarize;
      if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task rdchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
      h.rd(a, d, ok);
      if (!ok) begin
         n_fail++;
         summarize();
      end
      chk(d, exp, nm);
   endtask : rdchk
   task expect_now;
      c = !uv ? 2'h0 : ov ? 2'h2 : !hd ? 2'h1 : 2'h3;
      e18 = {batt, bc inside {[3'h1:3'h5]}, c == 2'h3, !(zn inside {3'h1, 3'h4}) && tm == 2'h0, 4'h0};
      e19 = {c, 1'b0, temp > 8'h50 + 8'h05 * {5'h00, sel}, 4'h0};
   endtask : expect_now
   initial begin
      repeat (5) @(negedge clock_in);
      rst_in = 0;
      rdchk(8'h18, 8'h10, "summary reset");
      rdchk(8'h19, 8'h00, "input reset");
      for (int i = 0; i < 48; i++) begin
         s = xs(s);
         {batt, tm, uv, ov, hd} = s[5:0];
         bc = s[9:7];
         zn = s[12:10] % 3'h5;
         sel = s[15:13];
         // first passes walk every battery and threshold code and sit exactly on the threshold
         if (i < 8) {bc, sel, uv, ov, hd} = {i[2:0], i[2:0], i[2:0]};
         temp = 8'h4F + 8'h05 * {5'h00, sel} + (i < 8 ? 8'h01 : {6'h00, s[17:16]});
         ilim = i % 4 == 3;
         if (!ilim) expect_now();
         h.wr(i[0] ? 8'h18 : 8'h19, s[31:24]);
         @(negedge clock_in);
         rdchk(8'h18, e18, "summary");
         rdchk(8'h19, e19, "input");
         chk({pf, sg, hl, tf, 4'h0}, {e18[7], e18[5:4], e19[4], 4'h0}, "flags");
         rdchk(s[23:16] | 8'h20, 8'h00, "unmapped");
      end
      summarize();
   end
endmodule : testbench
